// ### logic/obcl_pkg.sv
// Shared constants and types of the option byte configuration loader.
package obcl_pkg;
    // ------------------------------------------------------------
    // Flash area and register map
    // ------------------------------------------------------------
    localparam int unsigned OB_COUNT        = 4;
    localparam logic [16:0] OB_PRIMARY_BASE = 17'h000c0;
    localparam logic [16:0] OB_SWAP_BASE    = 17'h010c0;
    localparam logic [7:0]  IDX_WD          = 8'hc0;
    localparam logic [7:0]  IDX_VDET        = 8'hc1;
    localparam logic [7:0]  IDX_CLK         = 8'hc2;
    localparam logic [7:0]  IDX_DBG         = 8'hc3;
    localparam logic [7:0]  IDX_STAT        = 8'hc4;
    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int unsigned WD_IRQ_BIT   = 7;
    localparam int unsigned WD_WIN_HI    = 6;
    localparam int unsigned WD_WIN_LO    = 5;
    localparam int unsigned WD_RUN_BIT   = 4;
    localparam int unsigned WD_TO_HI     = 3;
    localparam int unsigned WD_TO_LO     = 1;
    localparam int unsigned WD_STBY_BIT  = 0;
    localparam int unsigned VD_LVL_HI    = 7;
    localparam int unsigned VD_LVL_LO    = 5;
    localparam int unsigned VD_STEP_HI   = 3;
    localparam int unsigned VD_STEP_LO   = 2;
    localparam int unsigned VD_MODE_HI   = 1;
    localparam int unsigned VD_MODE_LO   = 0;
    localparam int unsigned FL_HI        = 7;
    localparam int unsigned FL_LO        = 6;
    localparam int unsigned OSC_HI       = 3;
    localparam int unsigned OSC_LO       = 0;
    localparam int unsigned DBG_EN_BIT   = 7;
    localparam int unsigned DBG_KEEP_BIT = 0;
    localparam logic [1:0]  WIN_HALF     = 2'h1;
    localparam logic [1:0]  WIN_FULL     = 2'h3;
    localparam logic [1:0]  FL_LOW       = 2'h2;
    localparam logic [1:0]  FL_HIGH      = 2'h3;
    localparam logic [1:0]  DBG_BAD      = 2'h1;
    // ------------------------------------------------------------
    // Status register layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned ST_DONE_BIT  = 0;
    localparam int unsigned ST_SWAP_BIT  = 1;
    localparam int unsigned ST_ERR_LO    = 8;
    localparam int unsigned ERR_N        = 5;
    localparam logic [4:0]  RST_TO_LOG2  = 5'h00;
    localparam logic [4:0]  RST_OSC_MHZ  = 5'h00;
    localparam logic [3:0]  RST_LVL_IDX  = 4'h0;

    typedef enum logic [1:0] {
        VD_INT_RST = 2'b00,
        VD_RST     = 2'b01,
        VD_INT     = 2'b10,
        VD_OFF     = 2'b11
    } obcl_vdet_e;

    typedef enum logic [1:0] {
        FS_START = 2'b00,
        FS_REQ   = 2'b01,
        FS_DONE  = 2'b10
    } obcl_fetch_e;
endpackage

// ### logic/obcl_store_if.sv
// Byte stream from the flash fetcher to the store and the decoder.
interface obcl_store_if;
    logic       wrEn;
    logic [1:0] wrIdx;
    logic [7:0] wrData;
    logic       loadDone;

    modport fetch (output wrEn, output wrIdx, output wrData,
                   output loadDone);
    modport store (input wrEn, input wrIdx, input wrData);
    modport cons  (input wrEn, input wrIdx, input wrData,
                   input loadDone);
endinterface

// ### logic/obcl_byte_store.sv
// Small memory holding the fetched option bytes for bus readback.
module obcl_byte_store #(
    parameter int unsigned DEPTH = 4
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    obcl_store_if.store     st,
    input  wire logic [1:0] rdIdx,
    output logic      [7:0] rdData
);
    logic [7:0] mem_q [DEPTH];

    if (DEPTH != 4) begin : g_chk
        $error("obcl_byte_store: DEPTH must be 4");
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                mem_q[i] <= 8'h00;
            end else if (st.wrEn && st.wrIdx == 2'(i)) begin
                mem_q[i] <= st.wrData;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= mem_q[rdIdx];
        end
    end
endmodule

// ### logic/obcl_loader.sv
// Option byte loader: flash fetch, decode and Wishbone readback.
// Rules of the document
// R1: Option area is four bytes at c0-c3.
// R2: Bytes 0-2 user settings, byte 3 debug.
// R3: Every reset fetches and applies the bytes.
// R4: Boot swap fetches from 10c0-10c3 instead.
// R5: Programmer keeps both areas identical.
// R6: Programmer keeps unused bits, always programs bytes.
// R7: Byte0 bit7 enables watchdog interval interrupt.
// R8: Byte0 bits6:5 window 01=50%, 11=100%.
// R9: Byte0 bit4 starts watchdog after reset.
// R10: Byte0 bits3:1 pick watchdog overflow exponent.
// R11: Byte0 bit0 keeps watchdog running in standby.
// R12: Standby-run clear forces window to 100%.
// R13: Byte1 mode bits; bit7 and bit0 mean off.
// R14: Interrupt-reset mode uses low and high selects.
// R15: Reset mode picks one of twelve levels.
// R16: Interrupt mode uses reset-mode level encoding.
// R17: Programmer sets byte1 bit4 to one.
// R18: Byte2 bits7:6 pick low or high speed.
// R19: Programmer writes byte2 bits5:4 as 10.
// R20: Byte2 bits3:0 pick oscillator frequency.
// R21: Debug bits 7,0 pick enable and erase policy.
// R22: Programmer writes debug bits6:1 as 000010.
// R23: Outputs latch once per reset, then hold.
module obcl_loader #(
    parameter int unsigned ADR_W = 12
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         bootSwap,
    output logic              flashReq,
    output logic       [16:0] flashAddr,
    input  wire logic         flashAck,
    input  wire logic  [7:0]  flashData,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic  [3:0]  wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    output logic              cfgValid,
    output logic              wdIntervalIrqEn,
    output logic              wdOpenPeriodFull,
    output logic              wdCounterRun,
    output logic       [2:0]  wdTimeoutSel,
    output logic       [4:0]  wdTimeoutLog2,
    output logic              wdStandbyRun,
    output obcl_pkg::obcl_vdet_e vdetMode,
    output logic       [2:0]  vdetLowSel,
    output logic       [1:0]  vdetHighSel,
    output logic       [3:0]  vdetLevelIdx,
    output logic              flashHighSpeed,
    output logic       [4:0]  oscFreqMhz,
    output logic              debugEnable,
    output logic              debugKeepFlashOnFail
);
    // ------------------------------------------------------------
    // Parameter check and sub-blocks
    // ------------------------------------------------------------
    if (ADR_W < 11) begin : g_chk
        $error("obcl_loader: ADR_W must be at least 11");
    end

    obcl_store_if sif ();
    logic       swapUsed;
    logic [7:0] storeData;
    logic       loaded_q;

    obcl_fetch u_fetch (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .bootSwap  (bootSwap),
        .flashAck  (flashAck),
        .flashData (flashData),
        .flashReq  (flashReq),
        .flashAddr (flashAddr),
        .swapUsed  (swapUsed),
        .st        (sif.fetch)
    );

    obcl_byte_store #(.DEPTH(obcl_pkg::OB_COUNT)) u_store (
        .clk     (clk),
        .sys_rst (sys_rst),
        .st      (sif.store),
        .rdIdx   (wb_adr_i[3:2]),
        .rdData  (storeData)
    );

    // ------------------------------------------------------------
    // Lookup helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] toLog2(input logic [2:0] s);
        logic [4:0] r;
        r = 5'h06;
        case (s)
            3'h0: r = 5'h06;
            3'h1: r = 5'h07;
            3'h2: r = 5'h08;
            3'h3: r = 5'h09;
            3'h4: r = 5'h0b;
            3'h5: r = 5'h0d;
            3'h6: r = 5'h0e;
            default: r = 5'h10;
        endcase
        return r;
    endfunction

    // Returns the MHz value; zero MHz marks a prohibited code.
    function automatic logic [4:0] toMhz(input logic [3:0] s);
        logic [4:0] r;
        r = 5'h00;
        case (s)
            4'h0: r = 5'h18;
            4'h9: r = 5'h10;
            4'h1: r = 5'h0c;
            4'ha: r = 5'h08;
            4'h2: r = 5'h06;
            4'hb: r = 5'h04;
            4'h3: r = 5'h03;
            4'hc: r = 5'h02;
            4'hd: r = 5'h01;
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    // Single-level index 0..11 in rising voltage order; bit 4 = valid.
    function automatic logic [4:0] toLevel(input logic [2:0] v,
                                           input logic [1:0] s);
        logic [3:0] base;
        logic [1:0] off;
        logic       ok;
        base = 4'h0;
        off  = 2'h0;
        ok   = 1'b1;
        case (v)
            3'h1: base = 4'h0;
            3'h2: base = 4'h3;
            3'h3: base = 4'h6;
            3'h0: base = 4'h9;
            default: ok = 1'b0;
        endcase
        if (v == 3'h0) begin
            if (s == 2'h1) begin
                ok = 1'b0;
            end else begin
                off = (s == 2'h0) ? 2'h0 : ((s == 2'h2) ? 2'h1 : 2'h2);
            end
        end else begin
            if (s == 2'h0) begin
                ok = 1'b0;
            end else begin
                off = 2'h3 - s;
            end
        end
        return {ok, 4'(base + {2'h0, off})};
    endfunction

    // ------------------------------------------------------------
    // Load tracking
    // ------------------------------------------------------------
    logic wr0;
    logic wr1;
    logic wr2;
    logic wr3;
    assign wr0 = sif.wrEn && !loaded_q && sif.wrIdx == 2'h0; // R2
    assign wr1 = sif.wrEn && !loaded_q && sif.wrIdx == 2'h1;
    assign wr2 = sif.wrEn && !loaded_q && sif.wrIdx == 2'h2;
    assign wr3 = sif.wrEn && !loaded_q && sif.wrIdx == 2'h3; // R2

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loaded_q <= 1'b0;
            cfgValid <= 1'b0;
        end else if (sif.loadDone && !loaded_q) begin
            loaded_q <= 1'b1; // R23
            cfgValid <= 1'b1; // R3
        end
    end

    // ------------------------------------------------------------
    // Watchdog byte
    // ------------------------------------------------------------
    logic [7:0] b0;
    assign b0 = sif.wrData;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdIntervalIrqEn  <= 1'b0;
            wdOpenPeriodFull <= 1'b1;
            wdCounterRun     <= 1'b0;
            wdTimeoutSel     <= 3'h0;
            wdTimeoutLog2    <= obcl_pkg::RST_TO_LOG2;
            wdStandbyRun     <= 1'b0;
        end else if (wr0) begin
            wdIntervalIrqEn <= b0[obcl_pkg::WD_IRQ_BIT]; // R7
            wdCounterRun    <= b0[obcl_pkg::WD_RUN_BIT]; // R9
            wdTimeoutSel    <=
                b0[obcl_pkg::WD_TO_HI:obcl_pkg::WD_TO_LO]; // R10
            wdTimeoutLog2   <=
                toLog2(b0[obcl_pkg::WD_TO_HI:obcl_pkg::WD_TO_LO]); // R10
            wdStandbyRun    <= b0[obcl_pkg::WD_STBY_BIT]; // R11
            wdOpenPeriodFull <= !b0[obcl_pkg::WD_STBY_BIT] // R12
                || b0[obcl_pkg::WD_WIN_HI:obcl_pkg::WD_WIN_LO]
                   != obcl_pkg::WIN_HALF; // R8
        end
    end

    // ------------------------------------------------------------
    // Voltage detector byte
    // ------------------------------------------------------------
    logic [2:0] vLvl;
    logic [1:0] vStep;
    logic [1:0] vMode;
    logic [4:0] vSingle;
    logic       vOff;
    assign vLvl    = sif.wrData[obcl_pkg::VD_LVL_HI:obcl_pkg::VD_LVL_LO];
    assign vStep   = sif.wrData[obcl_pkg::VD_STEP_HI:obcl_pkg::VD_STEP_LO];
    assign vMode   = sif.wrData[obcl_pkg::VD_MODE_HI:obcl_pkg::VD_MODE_LO];
    assign vSingle = toLevel(vLvl, vStep);
    assign vOff    = vLvl[2] && vMode[0]; // R13

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vdetMode     <= obcl_pkg::VD_RST;
            vdetLowSel   <= 3'h0;
            vdetHighSel  <= 2'h0;
            vdetLevelIdx <= obcl_pkg::RST_LVL_IDX;
        end else if (wr1) begin
            vdetLowSel   <= vLvl; // R14
            vdetHighSel  <= vStep; // R14
            vdetLevelIdx <= vSingle[3:0]; // R15
            if (vOff) begin
                vdetMode <= obcl_pkg::VD_OFF; // R13
            end else if (vMode == 2'h2) begin
                vdetMode <= obcl_pkg::VD_INT_RST; // R13
            end else if (vMode == 2'h1) begin
                vdetMode <= obcl_pkg::VD_INT; // R16
            end else begin
                vdetMode <= obcl_pkg::VD_RST; // R13
            end
        end
    end

    // ------------------------------------------------------------
    // Clock, flash mode and debug bytes
    // ------------------------------------------------------------
    logic [1:0] flSel;
    logic [4:0] mhz;
    logic [1:0] dbgSel;
    assign flSel  = sif.wrData[obcl_pkg::FL_HI:obcl_pkg::FL_LO];
    assign mhz    = toMhz(sif.wrData[obcl_pkg::OSC_HI:obcl_pkg::OSC_LO]);
    assign dbgSel = {sif.wrData[obcl_pkg::DBG_EN_BIT],
                     sif.wrData[obcl_pkg::DBG_KEEP_BIT]};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flashHighSpeed <= 1'b0;
            oscFreqMhz     <= obcl_pkg::RST_OSC_MHZ;
        end else if (wr2) begin
            flashHighSpeed <= flSel == obcl_pkg::FL_HIGH; // R18
            oscFreqMhz     <= mhz; // R20
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            debugEnable          <= 1'b0;
            debugKeepFlashOnFail <= 1'b0;
        end else if (wr3) begin
            // A prohibited code leaves debug disabled.
            debugEnable          <= dbgSel[1]; // R21
            debugKeepFlashOnFail <= dbgSel == 2'h3; // R21
        end
    end

    // ------------------------------------------------------------
    // Sticky error flags for prohibited codes
    // ------------------------------------------------------------
    logic [obcl_pkg::ERR_N-1:0] err_q;
    logic [obcl_pkg::ERR_N-1:0] errSet;
    logic [obcl_pkg::ERR_N-1:0] errClr;
    logic                       vBad;
    logic                       wbWrite;
    logic                       hitStat;

    always_comb begin
        vBad = 1'b0;
        if (!vOff) begin
            if (vMode == 2'h2) begin
                vBad = vLvl == 3'h0 || vLvl[2] || vStep == 2'h3; // R14
            end else if (vMode == 2'h0) begin
                vBad = 1'b1;
            end else begin
                vBad = !vSingle[4]; // R15
            end
        end
    end

    assign errSet[0] = wr0 &&
        b0[obcl_pkg::WD_WIN_HI:obcl_pkg::WD_WIN_LO] != obcl_pkg::WIN_HALF &&
        b0[obcl_pkg::WD_WIN_HI:obcl_pkg::WD_WIN_LO] != obcl_pkg::WIN_FULL;
    assign errSet[1] = wr1 && vBad;
    assign errSet[2] = wr2 && flSel != obcl_pkg::FL_LOW
                           && flSel != obcl_pkg::FL_HIGH; // R18
    assign errSet[3] = wr2 && mhz == 5'h00; // R20
    assign errSet[4] = wr3 && dbgSel == obcl_pkg::DBG_BAD; // R21
    assign errClr = (wbWrite && hitStat && wb_sel_i[1])
        ? wb_dat_i[obcl_pkg::ST_ERR_LO +: obcl_pkg::ERR_N]
        : '0;

    // Set wins over a simultaneous write-one-to-clear.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_q <= '0;
        end else begin
            err_q <= (err_q & ~errClr) | errSet;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave: answers in the third cycle of a request
    // ------------------------------------------------------------
    logic       pend_q;
    logic [7:0] word;
    logic       hiZero;
    logic       hitByte;
    assign word    = wb_adr_i[9:2];
    assign hiZero  = wb_adr_i[ADR_W-1:10] == '0;
    assign hitByte = hiZero && word >= obcl_pkg::IDX_WD
                            && word <= obcl_pkg::IDX_DBG;
    assign hitStat = hiZero && word == obcl_pkg::IDX_STAT;
    assign wbWrite = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q   <= 1'b0;
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= 1'b0;
            if (wb_ack_o) begin
                pend_q <= 1'b0;
            end else if (pend_q) begin
                wb_ack_o <= 1'b1;
            end else if (wb_cyc_i && wb_stb_i) begin
                pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (pend_q && !wb_ack_o && !wb_we_i) begin
            if (hitByte) begin
                wb_dat_o <= {24'h00_0000, storeData};
            end else if (hitStat) begin
                wb_dat_o <= '0;
                wb_dat_o[obcl_pkg::ST_DONE_BIT] <= loaded_q;
                wb_dat_o[obcl_pkg::ST_SWAP_BIT] <= swapUsed;
                wb_dat_o[obcl_pkg::ST_ERR_LO +: obcl_pkg::ERR_N] <= err_q;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule

// ### logic/obcl_fetch.sv
// Reset-time sequencer that reads the four option bytes from flash.
module obcl_fetch (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        bootSwap,
    input  wire logic        flashAck,
    input  wire logic [7:0]  flashData,
    output logic             flashReq,
    output logic      [16:0] flashAddr,
    output logic             swapUsed,
    obcl_store_if.fetch      st
);
    obcl_pkg::obcl_fetch_e state_q;
    logic [1:0] idx_q;
    logic       wrEn_q;
    logic [1:0] wrIdx_q;
    logic [7:0] wrData_q;
    logic       done_q;

    assign st.wrEn     = wrEn_q;
    assign st.wrIdx    = wrIdx_q;
    assign st.wrData   = wrData_q;
    assign st.loadDone = done_q;

    // Request drops for one cycle after each accepted byte but the last.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= obcl_pkg::FS_START;
            idx_q     <= 2'h0;
            flashReq  <= 1'b0;
            flashAddr <= 17'h00000;
            swapUsed  <= 1'b0;
        end else begin
            case (state_q)
                obcl_pkg::FS_START: begin
                    swapUsed  <= bootSwap; // R4
                    flashAddr <= bootSwap ? obcl_pkg::OB_SWAP_BASE
                                          : obcl_pkg::OB_PRIMARY_BASE; // R1
                    state_q   <= obcl_pkg::FS_REQ; // R3
                end
                obcl_pkg::FS_REQ: begin
                    if (flashReq && flashAck) begin
                        flashReq  <= 1'b0;
                        idx_q     <= idx_q + 2'h1;
                        flashAddr <= flashAddr + 17'h00001;
                        if (idx_q == 2'h3) begin
                            state_q <= obcl_pkg::FS_DONE;
                        end
                    end else begin
                        flashReq <= 1'b1;
                    end
                end
                default: begin
                    flashReq <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrEn_q   <= 1'b0;
            wrIdx_q  <= 2'h0;
            wrData_q <= 8'h00;
            done_q   <= 1'b0;
        end else begin
            wrEn_q   <= state_q == obcl_pkg::FS_REQ && flashReq && flashAck;
            wrIdx_q  <= idx_q;
            wrData_q <= flashData;
            if (state_q == obcl_pkg::FS_REQ && flashReq && flashAck
                && idx_q == 2'h3) begin
                done_q <= 1'b1;
            end
        end
    end
endmodule

// ### verif/obcl_flash_model.sv
// Behavioural flash holding the primary and alternate option byte areas.
module obcl_flash_model (
    input  wire logic        clk,
    input  wire logic        flashReq,
    input  wire logic [16:0] flashAddr,
    input  wire logic [3:0]  lat,
    output logic             flashAck = 1'b0,
    output logic      [7:0]  flashData = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [8];
    logic [3:0] waitQ = 4'h0;
    // Data toggles while idle, so a stale byte never looks fresh.
    always @(posedge clk) begin
        if (flashReq && !flashAck && waitQ >= lat) begin
            flashAck  <= 1'b1;
            flashData <= mem[{flashAddr[12], flashAddr[1:0]}];
            waitQ     <= 4'h0;
        end else begin
            flashAck  <= 1'b0;
            flashData <= ~flashData;
            waitQ     <= (flashReq && !flashAck) ? waitQ + 4'h1 : 4'h0;
        end
    end
endmodule

// ### verif/obcl_loader_properties.sv
// Port-level checks for the option byte loader.
module obcl_loader_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        bootSwap,
    input wire logic        flashReq,
    input wire logic [16:0] flashAddr,
    input wire logic        flashAck,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        cfgValid,
    input wire logic        wdOpenPeriodFull,
    input wire logic        wdStandbyRun,
    input wire logic [2:0]  wdTimeoutSel,
    input wire logic [4:0]  wdTimeoutLog2
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] LOG2 [8] = '{5'h06, 5'h07, 5'h08, 5'h09,
                                        5'h0b, 5'h0d, 5'h0e, 5'h10};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence sTake; flashReq && flashAck; endsequence
    sequence sLast; sTake ##0 flashAddr[1:0] == 2'h3; endsequence
    AST_AREA: assert property (flashReq |->
        flashAddr[16:2] inside {15'h0030, 15'h0430}) else $error("bad area");
    AST_BASE: assert property ($rose(flashReq) &&
        flashAddr[1:0] == 2'h0 |-> flashAddr[12] == bootSwap)
        else $error("wrong base");
    AST_HOLD: assert property (flashReq && !flashAck |=>
        flashReq && $stable(flashAddr)) else $error("request dropped");
    AST_STEP: assert property (sTake ##0 flashAddr[1:0] != 2'h3 |=>
        !flashReq ##1 flashReq && flashAddr == $past(flashAddr, 2) + 17'h1)
        else $error("bad step");
    AST_LAST: assert property (sLast |-> ##[2:3] cfgValid)
        else $error("load not done");
    AST_IDLE: assert property (cfgValid |-> !flashReq)
        else $error("fetch after load");
    AST_KEEP: assert property (cfgValid |=> cfgValid &&
        $stable(wdTimeoutLog2)) else $error("settings moved");
    AST_TIMEOUT: assert property (cfgValid |->
        wdTimeoutLog2 == LOG2[wdTimeoutSel]) else $error("bad exponent");
    AST_WINDOW: assert property (cfgValid && !wdStandbyRun |->
        wdOpenPeriodFull) else $error("window not full");
    AST_ACK: assert property ($rose(wb_stb_i) |->
        !wb_ack_o ##2 wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
endmodule
bind obcl_loader obcl_loader_props u_props (.clk, .sys_rst, .bootSwap,
    .flashReq, .flashAddr, .flashAck, .wb_stb_i, .wb_ack_o, .cfgValid,
    .wdOpenPeriodFull, .wdStandbyRun, .wdTimeoutSel, .wdTimeoutLog2);

// ### verif/tb.sv
// Self-checking bench for the option byte loader.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, sys_rst, bootSwap, fReq, fAck, cyc, stb, we, ack, ok;
    logic        irqEn, full, run, stby, hs, dbgEn, keep;
    logic [16:0] fAddr;
    logic [11:0] adr;
    logic [7:0]  fData;
    logic [3:0]  lat, sel, lvl;
    logic [31:0] wdat, rdat, r;
    logic [2:0]  toSel, lowSel;
    logic [1:0]  highSel;
    logic [4:0]  log2, osc;
    obcl_pkg::obcl_vdet_e mode;
    int          bad_count, n_checks, cycles;
    logic [8:0]  oscTab [9] = '{9'h018, 9'h130, 9'h02c, 9'h148, 9'h046,
                                9'h164, 9'h063, 9'h182, 9'h1a1};
    logic [4:0]  toLog [8] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0d,
                               5'h0e, 5'h10};
    obcl_loader dut (.clk, .sys_rst, .bootSwap,
        .flashReq(fReq), .flashAddr(fAddr), .flashAck(fAck),
        .flashData(fData), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cfgValid(ok), .wdIntervalIrqEn(irqEn),
        .wdOpenPeriodFull(full), .wdCounterRun(run), .wdTimeoutSel(toSel),
        .wdTimeoutLog2(log2), .wdStandbyRun(stby), .vdetMode(mode),
        .vdetLowSel(lowSel), .vdetHighSel(highSel), .vdetLevelIdx(lvl),
        .flashHighSpeed(hs), .oscFreqMhz(osc), .debugEnable(dbgEn),
        .debugKeepFlashOnFail(keep));
    obcl_flash_model fm (.clk, .flashReq(fReq), .flashAddr(fAddr),
        .lat, .flashAck(fAck), .flashData(fData));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wrap_up;
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up;
        end
    end
    task automatic chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, logic [11:0] a, logic [31:0] d,
                      logic [3:0] s);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [11:0] a, logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(r, e);
    endtask
    // Resets twice, then waits for the load.
    task automatic load(input logic sw, logic [31:0] ob, logic [3:0] l);
        int n;
        for (n = 0; n < 4; n++) begin
            fm.mem[{sw, 2'(n)}] = ob[8*n +: 8];
            fm.mem[{!sw, 2'(n)}] = ~ob[8*n +: 8];
        end
        {bootSwap, lat, sys_rst} <= {sw, l, 1'b1};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ok !== 1'b1 && n < 200);
        for (n = 0; n < 4; n++) rd(12'h300 + 12'(4 * n), ob[8*n +: 8]);
    endtask
    initial begin
        {cyc, stb, we, adr, sel, wdat} = '0;
        load(1'b0, 32'h85ad5a36, 4'h0);
        chk({irqEn, full, run, toSel, log2, stby}, 12'h6d2);
        chk({mode, lowSel, highSel}, {obcl_pkg::VD_INT_RST, 5'h0a});
        chk({hs, osc, dbgEn, keep}, {1'b0, 5'h01, 2'b11});
        wb(1'b1, 12'h300, 32'hff, 4'hf);
        rd(12'h300, 32'h36);
        rd(12'h310, 32'h1);
        rd(12'h3f0, 32'h0);
        load(1'b1, 32'h04e95faf, 4'h3);
        chk({irqEn, full, run, toSel, log2, stby}, 12'h9e1);
        chk({mode, lvl}, {obcl_pkg::VD_RST, 4'h3});
        chk({hs, osc, dbgEn, keep}, {1'b1, 5'h10, 2'b00});
        rd(12'h310, 32'h3);
        load(1'b0, 32'h05af9101, 4'h1);
        chk({full, run, log2, stby}, 8'h8d);
        chk({mode, hs, osc, dbgEn, keep}, 10'h300);
        rd(12'h310, 32'h1901);
        wb(1'b1, 12'h310, 32'h100, 4'h1);
        rd(12'h310, 32'h1901);
        wb(1'b1, 12'h310, 32'h100, 4'h2);
        rd(12'h310, 32'h1801);
        for (int i = 0; i < 9; i++) begin
            load(1'b0, {8'h84, 4'he, oscTab[i][8:5], 8'h3d,
                 8'h31 | (8'(i % 8) << 1)}, 4'(i % 3));
            chk({full, log2, mode, lvl},
                {1'b0, toLog[i % 8], obcl_pkg::VD_INT, 4'h0});
            chk({hs, osc, dbgEn, keep}, {1'b1, oscTab[i][4:0], 2'b10});
        end
        wrap_up;
    end
endmodule
